//--- verilog/drs_defines.vh
// Purpose: Constants for the dual rail sequence and status block
// Assumes: 40 MHz clock
// Notes:   Strap codes are digitised resistor readings
`ifndef DRS_DEFINES_VH
`define DRS_DEFINES_VH
`define DRS_CLK_MHZ          40
`define DRS_NVM_LOAD_NS      2000
`define DRS_NVM_LOAD_CYC     ((`DRS_NVM_LOAD_NS*`DRS_CLK_MHZ+999)/1000)
`define DRS_LDO_SETTLE_NS    1000
`define DRS_LDO_SETTLE_CYC   ((`DRS_LDO_SETTLE_NS*`DRS_CLK_MHZ+999)/1000)
`define DRS_RETRY_NS         100000
`define DRS_RETRY_CYC        ((`DRS_RETRY_NS*`DRS_CLK_MHZ)/1000)
`define DRS_VT_W             10
`define DRS_VT_MIN           10'h080
`define DRS_VT_MAX           10'h307
`define DRS_BOOT_CODES       27
`define DRS_BOOT_BASE        10'h134
`define DRS_BOOT_STEP        10'h00c
`define DRS_SLEW_W           2
`define DRS_SLEW0_DIV        16'h0028
`define DRS_SLEW1_DIV        16'h0014
`define DRS_SLEW2_DIV        16'h000a
`define DRS_SLEW3_DIV        16'h0005
`define DRS_PWM_LOW          2'h0
`define DRS_PWM_HIGH         2'h1
`define DRS_PWM_MID          2'h2
`define DRS_PWM_ON_CYC       8'h08
`define DRS_PHASE_A_MAX      2'h3
`define DRS_PHASE_B_MAX      2'h2
`endif

//--- verilog/drs_rail.v
// Purpose: One rail: soft start, target ramp, fault latch, PWM
// Assumes: Inputs synchronous to clk
// Notes:   Target code steps one code per slew enable pulse
`timescale 1ns/1ps
`include "drs_defines.vh"
module drs_rail (
  // Clock and reset
  input  wire                  clk,
  input  wire                  nrst,
  // Control
  input  wire                  run,
  input  wire                  enable_in,
  input  wire                  to_boot_n,
  input  wire                  latch_mode,
  input  wire [1:0]            slew_sel,
  input  wire [`DRS_VT_W-1:0]  boot_code,
  input  wire [`DRS_VT_W-1:0]  target_in,
  input  wire [1:0]            phases,
  // Analog comparator results
  input  wire                  fault_in,
  input  wire                  cur_reach_comp,
  // Outputs
  output reg                   ready,
  output reg                   faulted,
  output reg  [`DRS_VT_W-1:0]  vt_code,
  output reg  [5:0]            pwm_state
);
  // ==========================================================
  // Slew divider and target ramp
  reg  [15:0]           div_cnt;
  reg  [15:0]           div_top;
  reg                   en_d;
  reg                   started;
  reg  [`DRS_VT_W-1:0]  goal;
  reg  [`DRS_VT_W-1:0]  next_vt;
  reg  [7:0]            on_cnt;
  reg  [1:0]            phase_ptr;
  reg  [31:0]           retry_cnt;
  wire                  active = run & enable_in & ~faulted;
  // A slew change can leave the count above the new top
  wire                  tick   = (div_cnt >= div_top);
  always @*
  begin
    case (slew_sel)
      2'h0:    div_top = `DRS_SLEW0_DIV;
      2'h1:    div_top = `DRS_SLEW1_DIV;
      2'h2:    div_top = `DRS_SLEW2_DIV;
      default: div_top = `DRS_SLEW3_DIV;
    endcase
    if (!started || !to_boot_n)
      goal = boot_code;
    else if (target_in < `DRS_VT_MIN)
      goal = `DRS_VT_MIN;
    else if (target_in > `DRS_VT_MAX)
      goal = `DRS_VT_MAX;
    else
      goal = target_in;
    next_vt = vt_code;
    if (tick && vt_code < goal)
      next_vt = vt_code + 10'h001;
    else if (tick && vt_code > goal)
      next_vt = vt_code - 10'h001;
  end
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      div_cnt   <= 16'h0000;
      vt_code   <= 10'h000;
      started   <= 1'b0;
      ready     <= 1'b0;
      faulted   <= 1'b0;
      en_d      <= 1'b0;
      retry_cnt <= 32'h0;
    end
    else
    begin
      en_d    <= enable_in;
      div_cnt <= (tick || !active) ? 16'h0000 : div_cnt + 16'h0001;
      if (!active)
      begin
        vt_code <= 10'h000;
        started <= 1'b0;
        ready   <= 1'b0;
      end
      else
      begin
        vt_code <= next_vt;
        if (!started && vt_code == boot_code)
        begin
          started <= 1'b1;
          ready   <= 1'b1;
        end
      end
      // Fault latch; a new fault outranks any clear
      if (fault_in && run && enable_in)
      begin
        faulted   <= 1'b1;
        retry_cnt <= 32'h0;
      end
      else if (enable_in && !en_d)
        faulted <= 1'b0;
      else if (faulted && !latch_mode)
      begin
        if (retry_cnt == `DRS_RETRY_CYC - 1)
          faulted <= 1'b0;
        retry_cnt <= retry_cnt + 32'h1;
      end
    end
  end
  // ==========================================================
  // PWM pulse start, phase rotation, protective state
  genvar g;
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      on_cnt    <= 8'h00;
      phase_ptr <= 2'h0;
    end
    else if (!active || phases == 2'h0)
    begin
      on_cnt    <= 8'h00;
      phase_ptr <= 2'h0;
    end
    else if (on_cnt != 8'h00)
      on_cnt <= on_cnt - 8'h01;
    else if (cur_reach_comp)
    begin
      on_cnt    <= `DRS_PWM_ON_CYC;
      phase_ptr <= (phase_ptr + 2'h1 >= phases) ? 2'h0
                                                : phase_ptr + 2'h1;
    end
  end
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_ph
      always @(posedge clk)
      begin
        if (!nrst)
          pwm_state[2*g+1:2*g] <= `DRS_PWM_MID;
        else if (faulted || !active || g >= phases)
          pwm_state[2*g+1:2*g] <= `DRS_PWM_MID;
        else if (on_cnt != 8'h00 && phase_ptr == g)
          pwm_state[2*g+1:2*g] <= `DRS_PWM_HIGH;
        else
          pwm_state[2*g+1:2*g] <= `DRS_PWM_LOW;
      end
    end
  endgenerate
endmodule // drs_rail

//--- verilog/drs_top.v
// Purpose: Power-on order, strap decode, rail status and PWM
// Assumes: Open-drain pins: out value 0 with oe_n low pulls low
// Notes:   Strap inputs are already-digitised codes
`timescale 1ns/1ps
`include "drs_defines.vh"
module drs_top (
  // Clock and reset
  input  wire                  clk,
  input  wire                  nrst,
  // Power-on detectors
  input  wire                  nvm_power_on_level,
  input  wire                  main_power_on_level,
  input  wire                  vin_below_thresh,
  // Stored configuration from NVM
  input  wire [`DRS_VT_W-1:0]  nvm_target_a,
  input  wire [`DRS_VT_W-1:0]  nvm_target_b,
  input  wire [1:0]            nvm_slew_sel,
  input  wire                  nvm_latch_mode,
  input  wire [1:0]            nvm_phases_a,
  input  wire [1:0]            nvm_phases_b,
  // Runtime bus command values
  input  wire                  cmd_valid,
  input  wire [`DRS_VT_W-1:0]  cmd_target_a,
  input  wire [`DRS_VT_W-1:0]  cmd_target_b,
  input  wire [1:0]            cmd_slew_sel,
  input  wire                  alert_req,
  // Straps
  input  wire [4:0]            rail_a_boot_strap,
  input  wire [4:0]            rail_b_boot_strap,
  input  wire [3:0]            common_strap,
  input  wire [1:0]            rail_a_strap,
  input  wire [1:0]            rail_b_strap,
  // Host pins
  input  wire                  rail_a_enable_in,
  input  wire                  rail_b_enable_in,
  input  wire                  return_boot_n,
  // Analog sense results
  input  wire                  over_temp_warn,
  input  wire                  fault_a,
  input  wire                  fault_b,
  input  wire                  cur_reach_comp_a,
  input  wire                  cur_reach_comp_b,
  // Open-drain status pins
  output reg                   rail_a_ready_out,
  output reg                   rail_a_ready_oe_n,
  output reg                   rail_b_ready_out,
  output reg                   rail_b_ready_oe_n,
  output reg                   thermal_warn_n,
  output reg                   thermal_warn_oe_n,
  output reg                   alert_n,
  output reg                   alert_oe_n,
  // Sequencing and decoded settings
  output reg                   ldo_enable,
  output reg                   config_done,
  output reg                   input_low_lockout,
  output reg  [3:0]            bus_address,
  output reg                   rail_a_power_stage_type,
  output reg                   rail_a_loadline_en,
  output reg                   rail_b_power_stage_type,
  output reg                   rail_b_loadline_en,
  output reg  [`DRS_VT_W-1:0]  rail_a_voltage_target_code,
  output reg  [`DRS_VT_W-1:0]  rail_b_voltage_target_code,
  // PWM states, two bits per phase
  output reg  [5:0]            rail_a_phase_pwm,
  output reg  [3:0]            rail_b_phase_pwm
);
  // ==========================================================
  // Power-on sequencer
  localparam ST_OFF   = 3'h0;
  localparam ST_NVM   = 3'h1;
  localparam ST_WPOR  = 3'h2;
  localparam ST_LDO   = 3'h3;
  localparam ST_STRAP = 3'h4;
  localparam ST_RUN   = 3'h5;
  reg  [2:0]            state;
  reg  [15:0]           seq_cnt;
  reg  [`DRS_VT_W-1:0]  tgt_a;
  reg  [`DRS_VT_W-1:0]  tgt_b;
  reg  [1:0]            slew_sel;
  reg                   latch_mode;
  reg  [1:0]            phases_a;
  reg  [1:0]            phases_b;
  reg  [`DRS_VT_W-1:0]  boot_a;
  reg  [`DRS_VT_W-1:0]  boot_b;
  reg                   alert_flag;
  wire                  run = (state == ST_RUN) & ~input_low_lockout;
  wire                  rdy_a;
  wire                  rdy_b;
  wire                  flt_a;
  wire                  flt_b;
  wire [`DRS_VT_W-1:0]  vt_a;
  wire [`DRS_VT_W-1:0]  vt_b;
  wire [5:0]            pwm_a;
  wire [5:0]            pwm_b;

  // Strap index to boot code, out-of-range codes take the top
  function [`DRS_VT_W-1:0] boot_of;
    input [4:0] idx;
    reg   [4:0] sat;
    begin
      sat = (idx >= `DRS_BOOT_CODES) ? 5'd26 : idx;
      boot_of = `DRS_BOOT_BASE + `DRS_BOOT_STEP * {5'h00, sat};
    end
  endfunction

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      state      <= ST_OFF;
      seq_cnt    <= 16'h0000;
      ldo_enable <= 1'b0;
      config_done <= 1'b0;
      tgt_a      <= `DRS_VT_MIN;
      tgt_b      <= `DRS_VT_MIN;
      slew_sel   <= 2'h0;
      latch_mode <= 1'b1;
      phases_a   <= 2'h0;
      phases_b   <= 2'h0;
      boot_a     <= `DRS_BOOT_BASE;
      boot_b     <= `DRS_BOOT_BASE;
      bus_address             <= 4'h0;
      rail_a_power_stage_type <= 1'b0;
      rail_a_loadline_en      <= 1'b0;
      rail_b_power_stage_type <= 1'b0;
      rail_b_loadline_en      <= 1'b0;
    end
    else if (!nvm_power_on_level)
    begin
      state       <= ST_OFF;
      ldo_enable  <= 1'b0;
      config_done <= 1'b0;
    end
    else
    begin
      case (state)
        ST_OFF:
        begin
          seq_cnt <= 16'h0000;
          state   <= ST_NVM;
        end
        ST_NVM:
        begin
          tgt_a      <= nvm_target_a;
          tgt_b      <= nvm_target_b;
          slew_sel   <= nvm_slew_sel;
          latch_mode <= nvm_latch_mode;
          phases_a   <= (nvm_phases_a > `DRS_PHASE_A_MAX)
                        ? `DRS_PHASE_A_MAX : nvm_phases_a;
          phases_b   <= (nvm_phases_b > `DRS_PHASE_B_MAX)
                        ? `DRS_PHASE_B_MAX : nvm_phases_b;
          seq_cnt    <= seq_cnt + 16'h0001;
          if (seq_cnt == `DRS_NVM_LOAD_CYC - 1)
            state <= ST_WPOR;
        end
        ST_WPOR:
        begin
          seq_cnt <= 16'h0000;
          if (main_power_on_level)
          begin
            ldo_enable <= 1'b1;
            state      <= ST_LDO;
          end
        end
        ST_LDO:
        begin
          seq_cnt <= seq_cnt + 16'h0001;
          if (seq_cnt == `DRS_LDO_SETTLE_CYC - 1)
            state <= ST_STRAP;
        end
        ST_STRAP:
        begin
          boot_a <= boot_of(rail_a_boot_strap);
          boot_b <= boot_of(rail_b_boot_strap);
          bus_address             <= common_strap;
          rail_a_power_stage_type <= rail_a_strap[0];
          rail_a_loadline_en      <= rail_a_strap[1];
          rail_b_power_stage_type <= rail_b_strap[0];
          rail_b_loadline_en      <= rail_b_strap[1];
          config_done <= 1'b1;
          state       <= ST_RUN;
        end
        ST_RUN:
        begin
          if (cmd_valid)
          begin
            tgt_a    <= cmd_target_a;
            tgt_b    <= cmd_target_b;
            slew_sel <= cmd_slew_sel;
          end
        end
        default:
          state <= ST_OFF;
      endcase
    end
  end

  // ==========================================================
  // Lockout, alert and pin drivers
  always @(posedge clk)
  begin
    if (!nrst)
    begin
      input_low_lockout <= 1'b1;
      alert_flag        <= 1'b0;
      rail_a_ready_out  <= 1'b0;
      rail_a_ready_oe_n <= 1'b0;
      rail_b_ready_out  <= 1'b0;
      rail_b_ready_oe_n <= 1'b0;
      thermal_warn_n    <= 1'b0;
      thermal_warn_oe_n <= 1'b1;
      alert_n           <= 1'b0;
      alert_oe_n        <= 1'b1;
      rail_a_voltage_target_code <= 10'h000;
      rail_b_voltage_target_code <= 10'h000;
      rail_a_phase_pwm  <= {3{`DRS_PWM_MID}};
      rail_b_phase_pwm  <= {2{`DRS_PWM_MID}};
    end
    else
    begin
      input_low_lockout <= vin_below_thresh | ~main_power_on_level;
      // Host request or new fault; fault wins over a clear
      alert_flag <= alert_req | (fault_a & ~flt_a) | (fault_b & ~flt_b)
                    | (alert_flag & ~cmd_valid);
      rail_a_ready_out  <= 1'b0;
      rail_a_ready_oe_n <= rdy_a;
      rail_b_ready_out  <= 1'b0;
      rail_b_ready_oe_n <= rdy_b;
      thermal_warn_n    <= 1'b0;
      thermal_warn_oe_n <= ~over_temp_warn;
      alert_n           <= 1'b0;
      alert_oe_n        <= ~alert_flag;
      rail_a_voltage_target_code <= vt_a;
      rail_b_voltage_target_code <= vt_b;
      rail_a_phase_pwm  <= pwm_a;
      rail_b_phase_pwm  <= pwm_b[3:0];
    end
  end

  // ==========================================================
  // Rails
  drs_rail u_rail_a (
    .clk            (clk),
    .nrst           (nrst),
    .run            (run),
    .enable_in      (rail_a_enable_in),
    .to_boot_n      (return_boot_n),
    .latch_mode     (latch_mode),
    .slew_sel       (slew_sel),
    .boot_code      (boot_a),
    .target_in      (tgt_a),
    .phases         (phases_a),
    .fault_in       (fault_a),
    .cur_reach_comp (cur_reach_comp_a),
    .ready          (rdy_a),
    .faulted        (flt_a),
    .vt_code        (vt_a),
    .pwm_state      (pwm_a)
  );
  drs_rail u_rail_b (
    .clk            (clk),
    .nrst           (nrst),
    .run            (run),
    .enable_in      (rail_b_enable_in),
    .to_boot_n      (return_boot_n),
    .latch_mode     (latch_mode),
    .slew_sel       (slew_sel),
    .boot_code      (boot_b),
    .target_in      (tgt_b),
    .phases         (phases_b),
    .fault_in       (fault_b),
    .cur_reach_comp (cur_reach_comp_b),
    .ready          (rdy_b),
    .faulted        (flt_b),
    .vt_code        (vt_b),
    .pwm_state      (pwm_b)
  );
endmodule // drs_top

//--- tb/drs_top_sva.sv
// Purpose: Port checks for the dual rail sequence block
// Assumes: One clock, sync active-low reset
// Notes:   Bound into drs_top
`timescale 1ns/1ps
`include "drs_defines.vh"
module drs_top_chk (
  // Inputs of the block
  input wire logic clk, nrst, nvm_power_on_level, main_power_on_level,
  input wire logic vin_below_thresh, alert_req, over_temp_warn,
  input wire logic rail_a_enable_in, fault_a,
  input wire logic [4:0] rail_b_boot_strap,
  // Outputs of the block
  input wire logic config_done, ldo_enable, input_low_lockout,
  input wire logic rail_a_ready_out, rail_a_ready_oe_n, rail_b_ready_out,
  input wire logic rail_b_ready_oe_n, thermal_warn_n, thermal_warn_oe_n,
  input wire logic alert_n, alert_oe_n,
  input wire logic [`DRS_VT_W-1:0] rail_b_voltage_target_code,
  input wire logic [5:0] rail_a_phase_pwm
);
  logic [`DRS_VT_W-1:0] boot_b;
  assign boot_b = `DRS_BOOT_BASE + `DRS_BOOT_STEP *
    ((rail_b_boot_strap > 5'h1a) ? 10'h01a : {5'h00, rail_b_boot_strap});
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Sequencing
  ldo_order_a: assert property ($rose(ldo_enable) |->
    $past(main_power_on_level) && $past(nvm_power_on_level, 60))
    else $error("regulator enabled out of order");
  strap_after_a: assert property ($rose(config_done) |->
    ldo_enable && $past(ldo_enable, 30)) else $error("straps too early");
  lockout_a: assert property (vin_below_thresh ||
    !main_power_on_level |-> ##[1:2] input_low_lockout)
    else $error("lockout not flagged");
  // ==========================================================
  // Status pins
  ready_idle_a: assert property (!rail_a_enable_in [*3]
    |-> !rail_a_ready_oe_n) else $error("ready while disabled");
  ready_fault_a: assert property (config_done && rail_a_enable_in
    && fault_a |-> ##[1:3] !rail_a_ready_oe_n) else $error("ready on fault");
  ready_boot_a: assert property ($rose(rail_b_ready_oe_n) |->
    rail_b_voltage_target_code == boot_b) else $error("ready off boot");
  hot_set_a: assert property (over_temp_warn [*3]
    |-> !thermal_warn_oe_n) else $error("thermal warning missing");
  hot_clr_a: assert property (!over_temp_warn [*3]
    |-> thermal_warn_oe_n) else $error("thermal warning stuck");
  alert_set_a: assert property (alert_req
    |-> ##[1:2] !alert_oe_n) else $error("alert missing");
  od_low_a: assert property (!(rail_a_ready_out || rail_b_ready_out
    || thermal_warn_n || alert_n)) else $error("open drain drives high");
  // ==========================================================
  // PWM
  pwm_fault_a: assert property (config_done && rail_a_enable_in
    && fault_a |-> ##[1:4] rail_a_phase_pwm == {3{`DRS_PWM_MID}})
    else $error("pwm not mid on fault");
  pwm_width_a: assert property ($rose(rail_a_phase_pwm[1:0] ==
    `DRS_PWM_HIGH) |-> (rail_a_phase_pwm[1:0] == `DRS_PWM_HIGH) [*8]
    ##1 rail_a_phase_pwm[1:0] != `DRS_PWM_HIGH) else $error("pulse width");
endmodule // drs_top_chk
bind drs_top drs_top_chk i_chk (.*);

//--- tb/drs_stage_model.sv
// Purpose: Power stage and current comparator model for one rail
// Assumes: period 0 keeps the comparator quiet
// Notes:   Fault is the stage report, one cycle late
`timescale 1ns/1ps
`include "drs_defines.vh"
module drs_stage_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // From the controller and the bench
  input  wire logic [5:0] pwm,
  input  wire logic [7:0] period,
  input  wire logic       fault_req,
  // To the controller
  output logic            cur_reach,
  output logic            fault
);
  logic [7:0] cnt;
  logic       on;
  assign on = (pwm[1:0] == `DRS_PWM_HIGH) || (pwm[3:2] == `DRS_PWM_HIGH)
    || (pwm[5:4] == `DRS_PWM_HIGH);
  always @(posedge clk)
  begin
    fault <= nrst && fault_req;
    cur_reach <= 1'b0;
    if (!nrst || on || period == 8'h00)
      cnt <= 8'h00;
    else if (cnt == period)
    begin
      cnt <= 8'h00;
      cur_reach <= 1'b1;
    end
    else
      cnt <= cnt + 8'h01;
  end
endmodule // drs_stage_model

//--- tb/tb_drs_top.sv
// Purpose: Directed test of the dual rail sequence block
// Assumes: Inputs change at the falling edge
// Notes:   Slew rate 3 keeps ramps short
`timescale 1ns/1ps
`include "drs_defines.vh"
module tb_drs_top;
  logic clk, nrst, nvm_power_on_level, main_power_on_level, vin_below_thresh;
  logic [9:0] nvm_target_a, nvm_target_b, cmd_target_a, cmd_target_b, c0;
  logic [1:0] nvm_slew_sel, nvm_phases_a, nvm_phases_b, cmd_slew_sel;
  logic nvm_latch_mode, cmd_valid, alert_req, rail_a_enable_in;
  logic rail_b_enable_in, return_boot_n, over_temp_warn, fault_a, fault_b;
  logic cur_reach_comp_a, cur_reach_comp_b, flt_a, flt_b;
  logic [4:0] rail_a_boot_strap, rail_b_boot_strap;
  logic [3:0] common_strap, bus_address, rail_b_phase_pwm, hi;
  logic [1:0] rail_a_strap, rail_b_strap;
  logic rail_a_ready_out, rail_a_ready_oe_n, rail_b_ready_out;
  logic rail_b_ready_oe_n, thermal_warn_n, thermal_warn_oe_n, alert_n;
  logic alert_oe_n, ldo_enable, config_done, input_low_lockout;
  logic rail_a_power_stage_type, rail_a_loadline_en;
  logic rail_b_power_stage_type, rail_b_loadline_en;
  logic [9:0] rail_a_voltage_target_code, rail_b_voltage_target_code;
  logic [5:0] rail_a_phase_pwm;
  logic [7:0] period_a, period_b;
  int num_errors, check_count, n;
  int dv[4] = '{`DRS_SLEW0_DIV + 1, `DRS_SLEW1_DIV + 1,
    `DRS_SLEW2_DIV + 1, `DRS_SLEW3_DIV + 1};
  localparam logic [9:0] BOOT = `DRS_BOOT_BASE + `DRS_BOOT_STEP * 10'h01a;
  drs_top i_drs_top (.*);
  drs_stage_model i_stage_a (.clk, .nrst, .pwm(rail_a_phase_pwm),
    .period(period_a), .fault_req(flt_a), .cur_reach(cur_reach_comp_a),
    .fault(fault_a));
  drs_stage_model i_stage_b (.clk, .nrst, .pwm({2'h0, rail_b_phase_pwm}),
    .period(period_b), .fault_req(flt_b), .cur_reach(cur_reach_comp_b),
    .fault(fault_b));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: return rail_a_ready_oe_n;
      1: return rail_b_ready_oe_n;
      default: return config_done;
    endcase
  endfunction
  task automatic wait_on(input int s, input logic lvl, input int lim);
    n = 0;
    while (pick(s) !== lvl && n < lim)
    begin
      cyc(1);
      n++;
    end
    chk(pick(s), lvl);
  endtask
  task automatic cmd(input logic [9:0] ta, tb, input logic [1:0] sel);
    cmd_target_a = ta;
    cmd_target_b = tb;
    cmd_slew_sel = sel;
    cmd_valid = 1'b1;
    cyc(1);
    cmd_valid = 1'b0;
  endtask
  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #(60000 * 25);
    num_errors++;
    print_verdict();
  end
  // ==========================================================
  // Main sequence
  initial
  begin
    {nrst, nvm_power_on_level, main_power_on_level, vin_below_thresh} = 0;
    {cmd_valid, alert_req, rail_a_enable_in, rail_b_enable_in} = 0;
    {over_temp_warn, flt_a, flt_b, period_a, period_b} = 0;
    {nvm_target_a, nvm_target_b} = {BOOT, BOOT};
    {nvm_slew_sel, nvm_latch_mode, nvm_phases_a, nvm_phases_b} = 7'h7d;
    {cmd_target_a, cmd_target_b, cmd_slew_sel, return_boot_n} = 1;
    {rail_a_boot_strap, rail_b_boot_strap} = {5'h1a, 5'h1f};
    {common_strap, rail_a_strap, rail_b_strap} = {4'ha, 2'h1, 2'h2};
    {num_errors, check_count} = 0;
    cyc(4);
    nrst = 1'b1;
    {nvm_power_on_level, main_power_on_level} = 2'h3;
    cyc(70);
    chk(ldo_enable, 1'b0);
    wait_on(2, 1'b1, 200);
    chk(ldo_enable, 1'b1);
    chk({bus_address, rail_a_power_stage_type, rail_a_loadline_en,
      rail_b_power_stage_type, rail_b_loadline_en}, 8'ha9);
    {rail_a_enable_in, rail_b_enable_in} = 2'h3;
    cyc(100);
    chk({rail_a_ready_oe_n, rail_b_ready_oe_n}, 2'h0);
    wait_on(0, 1'b1, 5000);
    wait_on(1, 1'b1, 100);
    chk(rail_a_voltage_target_code, BOOT);
    chk(rail_b_voltage_target_code, BOOT);
    for (int s = 0; s < 4; s++)
    begin
      c0 = rail_a_voltage_target_code;
      cmd(c0 + 10'h004, BOOT, s[1:0]);
      n = 0;
      while (rail_a_voltage_target_code === c0 && n < 100)
      begin
        cyc(1);
        n++;
      end
      n = 0;
      while (rail_a_voltage_target_code !== c0 + 10'h004 && n < 300)
      begin
        cyc(1);
        n++;
      end
      chk(n >= dv[s] * 3 - 1 && n <= dv[s] * 3 + 1, 1'b1);
    end
    cmd(10'h3ff, 10'h000, 2'h3);
    cyc(3200);
    chk(rail_a_voltage_target_code, `DRS_VT_MAX);
    chk(rail_b_voltage_target_code, `DRS_VT_MIN);
    return_boot_n = 1'b0;
    cyc(3200);
    chk({rail_a_voltage_target_code, rail_b_voltage_target_code},
      {BOOT, BOOT});
    cmd(BOOT, BOOT, 2'h3);
    return_boot_n = 1'b1;
    {over_temp_warn, alert_req} = 2'h3;
    cyc(4);
    chk({thermal_warn_oe_n, alert_oe_n, rail_a_ready_oe_n}, 3'h1);
    {over_temp_warn, alert_req} = 2'h0;
    cmd(BOOT, BOOT, 2'h3);
    cyc(3);
    chk({thermal_warn_oe_n, alert_oe_n}, 2'h3);
    {period_a, period_b} = {8'h10, 8'h10};
    hi = 4'h0;
    repeat (200)
    begin
      cyc(1);
      for (int p = 0; p < 3; p++)
        if (rail_a_phase_pwm[2*p+:2] === `DRS_PWM_HIGH)
          hi[p] = 1'b1;
      if (rail_b_phase_pwm[3:2] !== `DRS_PWM_MID)
        hi[3] = 1'b1;
    end
    chk(hi, 4'h7);
    {period_a, period_b} = 0;
    cyc(20);
    flt_a = 1'b1;
    cyc(5);
    chk({rail_a_ready_oe_n, rail_a_phase_pwm},
      {1'b0, {3{`DRS_PWM_MID}}});
    flt_a = 1'b0;
    cyc(4200);
    chk(rail_a_ready_oe_n, 1'b0);
    rail_a_enable_in = 1'b0;
    cyc(4);
    rail_a_enable_in = 1'b1;
    wait_on(0, 1'b1, 5000);
    {nvm_latch_mode, nvm_power_on_level} = 2'h0;
    cyc(4);
    nvm_power_on_level = 1'b1;
    wait_on(2, 1'b1, 300);
    wait_on(1, 1'b1, 5000);
    flt_b = 1'b1;
    cyc(5);
    flt_b = 1'b0;
    chk(rail_b_ready_oe_n, 1'b0);
    wait_on(1, 1'b1, 9000);
    vin_below_thresh = 1'b1;
    cyc(4);
    chk(input_low_lockout, 1'b1);
    print_verdict();
  end
endmodule // tb_drs_top
